// >>> rtl/mode_and_memory_map_config.v
// Purpose: Operating mode latch, RAM and register block placement, configuration latches and map decode
// Assumes: Mode pins are asynchronous; nonvolatile cell value and CPU address are on ref_clk_i
// Notes: Register reads answer one cycle after the read strobe; decode outputs lag the address by one cycle
//
// The implementer's own choice: the plain strobed port.

`include "mode_map_cfg_map.vh"

// Notes on behaviour
// - Mode pins latched at reset into special-mode flag and mode-select-A.
// - Both mode bits always readable; special-mode flag can only be written to zero.
// - Mode-select-A takes one write in normal modes, any number in special modes.
// - Boot ROM bit acts only with special-mode flag set; writable only in special modes.
// - Boot ROM visible at BE00 to BFFF when bit set, else absent.
// - Boot bit and mode bits reset according to the mode pins.
// - Mapping register: one write in first 64 cycles in normal modes; any time special.
// - Mapping upper nibble gives top four address bits of internal RAM.
// - Mapping lower nibble gives top four address bits of the register block.
// - Mapping resets to zero so RAM and registers both start at 0000.
// - Behaviour follows working latches loaded from nonvolatile cells each reset; reads return latches.
// - Newly programmed cell value only visible after the next reset sequence.
// - Unused configuration bit, bit 6 only, reads as one.
// - Configuration writable directly only with special-mode flag set.
// - Single-chip mode forces ROM placement bit to one out of reset.
// - ROM decodes at 2000 to 7FFF when placement low, A000 to FFFF when high.
// - Aux clock enable off disables the pin; on drives divided clock out.
// - Special test forces ROM enable to zero; single chip forces it to one.
module mode_and_memory_map_config (
	input wire ref_clk_i,
	input wire resetn_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire mode_pin_a_i,
	input wire mode_pin_b_i,
	input wire [7:0] nv_config_i,
	input wire [15:0] cpu_addr_i,
	output reg ram_select_o,
	output reg reg_select_o,
	output reg rom_select_o,
	output reg boot_rom_select_o,
	output reg special_mode_flag_o,
	output reg mode_select_a_o,
	output reg boot_rom_visible_o,
	output reg [3:0] ram_base_o,
	output reg [3:0] reg_base_o,
	output reg rom_high_placement_o,
	output reg rom_present_o,
	output reg watchdog_disable_o,
	output reg security_disable_o,
	output reg eeprom_present_o,
	output reg pullup_assign_enable_o,
	output reg config_ready_o,
	output wire aux_clock_pin_o
);

// ---------------------------------------------------------------
// States of the reset sequence
// ---------------------------------------------------------------
localparam ST_SYNC = 2'b00;
localparam ST_LOAD = 2'b01;
localparam ST_RUN = 2'b10;

// ---------------------------------------------------------------
// Functions
// ---------------------------------------------------------------
function in_range;
	input [15:0] a;
	input [15:0] lo;
	input [15:0] hi;
	begin
		in_range = (a >= lo) && (a <= hi);
	end
endfunction

function in_block;
	input [15:0] a;
	input [3:0] base;
	input [11:0] size;
	begin
		in_block = (a[15:12] == base) && (a[11:0] < size);
	end
endfunction

// ---------------------------------------------------------------
// Declarations
// ---------------------------------------------------------------
reg mode_a_meta;
reg mode_a_sync;
reg mode_b_meta;
reg mode_b_sync;
reg [1:0] state;
reg [1:0] next_state;
reg [1:0] sync_cnt;
reg [6:0] cycle_cnt;
reg boot_bit;
reg special_mode;
reg mode_a;
reg [4:0] psel;
reg mode_a_written;
reg [7:0] map_reg;
reg map_written;
reg [7:0] cfg_latch;
wire running;
wire wr_pmc;
wire wr_map;
wire wr_cfg;
wire map_window_open;
wire boot_effective;
wire map_may_write;
wire mode_a_may_write;
reg [7:0] next_rdata;
reg next_reg_sel;
reg next_ram_sel;
reg next_rom_sel;
reg next_boot_sel;

// ---------------------------------------------------------------
// Mode pin synchronisers
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		mode_a_meta <= 1'b0;
		mode_a_sync <= 1'b0;
		mode_b_meta <= 1'b0;
		mode_b_sync <= 1'b0;
	end else begin
		mode_a_meta <= mode_pin_a_i;
		mode_a_sync <= mode_a_meta;
		mode_b_meta <= mode_pin_b_i;
		mode_b_sync <= mode_b_meta;
	end
end

// ---------------------------------------------------------------
// Reset sequence
// ---------------------------------------------------------------
always @* begin
	next_state = state;
	case (state)
		ST_SYNC: begin
			if (sync_cnt == `SYNC_CYCLES) begin
				next_state = ST_LOAD;
			end
		end
		ST_LOAD: begin
			next_state = ST_RUN;
		end
		ST_RUN: begin
			next_state = ST_RUN;
		end
		default: begin
			next_state = ST_SYNC;
		end
	endcase
end

always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		state <= ST_SYNC;
		sync_cnt <= 2'h0;
	end else begin
		state <= next_state;
		if (state == ST_SYNC) begin
			sync_cnt <= sync_cnt + 2'h1;
		end
	end
end

// Cycles since reset release, saturating
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		cycle_cnt <= 7'h00;
	end else if (cycle_cnt != `MAP_WINDOW_CYCLES) begin
		cycle_cnt <= cycle_cnt + 7'h01;
	end
end

assign running = (state == ST_RUN);
assign map_window_open = (cycle_cnt < `MAP_WINDOW_CYCLES);
assign wr_pmc = wr_i && running && (addr_i == `OFS_PRIORITY_AND_MODE_CONTROL);
assign wr_map = wr_i && running && (addr_i == `OFS_RAM_REGISTER_MAP_POSITION);
assign wr_cfg = wr_i && running && (addr_i == `OFS_SYSTEM_CONFIGURATION_LATCHES);
assign mode_a_may_write = special_mode || !mode_a_written;
assign map_may_write = special_mode || (map_window_open && !map_written);
assign boot_effective = boot_bit && special_mode;

// ---------------------------------------------------------------
// Priority and mode control
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		boot_bit <= 1'b0;
		special_mode <= 1'b0;
		mode_a <= 1'b0;
		psel <= `PMC_PSEL_RST;
		mode_a_written <= 1'b0;
	end else if (state == ST_LOAD) begin
		special_mode <= ~mode_b_sync;
		mode_a <= mode_a_sync;
		boot_bit <= ~mode_b_sync && ~mode_a_sync;
	end else if (wr_pmc) begin
		if (!wdata_i[`PMC_SPECIAL_BIT]) begin
			special_mode <= 1'b0;
		end
		if (special_mode) begin
			boot_bit <= wdata_i[`PMC_BOOT_BIT];
		end
		if (mode_a_may_write) begin
			mode_a <= wdata_i[`PMC_MODE_A_BIT];
			mode_a_written <= 1'b1;
		end
		psel <= wdata_i[`PMC_PSEL_HI:0];
	end
end

// ---------------------------------------------------------------
// RAM and register block position
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		map_reg <= `MAP_RST;
		map_written <= 1'b0;
	end else if (wr_map && map_may_write) begin
		map_reg <= wdata_i;
		map_written <= 1'b1;
	end
end

// ---------------------------------------------------------------
// Configuration latches
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		cfg_latch <= `CFG_RST;
	end else if (state == ST_LOAD) begin
		cfg_latch <= nv_config_i | `CFG_UNUSED_MASK;
		if (mode_b_sync && !mode_a_sync) begin
			cfg_latch[`CFG_ROM_HIGH_BIT] <= 1'b1;
			cfg_latch[`CFG_ROM_ON_BIT] <= 1'b1;
		end
		if (!mode_b_sync && mode_a_sync) begin
			cfg_latch[`CFG_ROM_ON_BIT] <= 1'b0;
		end
	end else if (wr_cfg && special_mode) begin
		cfg_latch <= wdata_i | `CFG_UNUSED_MASK;
	end
end

// ---------------------------------------------------------------
// Register read port
// ---------------------------------------------------------------
always @* begin
	next_rdata = 8'h00;
	if (rd_i) begin
		case (addr_i)
			`OFS_PRIORITY_AND_MODE_CONTROL: begin
				next_rdata = {boot_bit, special_mode, mode_a, psel};
			end
			`OFS_RAM_REGISTER_MAP_POSITION: begin
				next_rdata = map_reg;
			end
			`OFS_SYSTEM_CONFIGURATION_LATCHES: begin
				next_rdata = cfg_latch | `CFG_UNUSED_MASK;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end
end

always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		rdata_o <= 8'h00;
	end else begin
		rdata_o <= next_rdata;
	end
end

// ---------------------------------------------------------------
// Memory map decode
// ---------------------------------------------------------------
always @* begin
	next_reg_sel = in_block(cpu_addr_i, map_reg[3:0], `REG_SIZE);
	next_ram_sel = in_block(cpu_addr_i, map_reg[7:4], `RAM_SIZE) && !next_reg_sel;
	next_boot_sel = boot_effective && in_range(cpu_addr_i, `BOOT_LO, `BOOT_HI);
	next_rom_sel = 1'b0;
	if (cfg_latch[`CFG_ROM_ON_BIT] && !next_reg_sel && !next_ram_sel && !next_boot_sel) begin
		if (cfg_latch[`CFG_ROM_HIGH_BIT]) begin
			next_rom_sel = in_range(cpu_addr_i, `ROM_HIGH_LO, `ROM_HIGH_HI);
		end else begin
			next_rom_sel = in_range(cpu_addr_i, `ROM_LOW_LO, `ROM_LOW_HI);
		end
	end
end

always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		reg_select_o <= 1'b0;
		ram_select_o <= 1'b0;
		rom_select_o <= 1'b0;
		boot_rom_select_o <= 1'b0;
	end else begin
		reg_select_o <= next_reg_sel && running;
		ram_select_o <= next_ram_sel && running;
		rom_select_o <= next_rom_sel && running;
		boot_rom_select_o <= next_boot_sel && running;
	end
end

// ---------------------------------------------------------------
// State outputs
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		special_mode_flag_o <= 1'b0;
		mode_select_a_o <= 1'b0;
		boot_rom_visible_o <= 1'b0;
		ram_base_o <= 4'h0;
		reg_base_o <= 4'h0;
		rom_high_placement_o <= 1'b1;
		rom_present_o <= 1'b1;
		watchdog_disable_o <= 1'b1;
		security_disable_o <= 1'b1;
		eeprom_present_o <= 1'b1;
		pullup_assign_enable_o <= 1'b1;
		config_ready_o <= 1'b0;
	end else begin
		special_mode_flag_o <= special_mode;
		mode_select_a_o <= mode_a;
		boot_rom_visible_o <= boot_effective;
		ram_base_o <= map_reg[7:4];
		reg_base_o <= map_reg[3:0];
		rom_high_placement_o <= cfg_latch[`CFG_ROM_HIGH_BIT];
		rom_present_o <= cfg_latch[`CFG_ROM_ON_BIT];
		watchdog_disable_o <= cfg_latch[`CFG_WDOG_OFF_BIT];
		security_disable_o <= cfg_latch[`CFG_SEC_OFF_BIT];
		eeprom_present_o <= cfg_latch[`CFG_EEPROM_ON_BIT];
		pullup_assign_enable_o <= cfg_latch[`CFG_PULLUP_BIT];
		config_ready_o <= running;
	end
end

// ---------------------------------------------------------------
// Auxiliary clock pin
// ---------------------------------------------------------------
aux_clock_divider aux_clock_divider_inst (
	.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i),
	.enable_i(cfg_latch[`CFG_AUX_CLK_BIT]),
	.aux_clock_o(aux_clock_pin_o)
);

endmodule // mode_and_memory_map_config

// >>> rtl/mode_map_cfg_map.vh
// Purpose: Offsets, fields, reset values and counts of the mode and memory map configuration block
// Assumes: Included by the design files of that block only
// Notes: Definitions only
`ifndef MODE_MAP_CFG_MAP_VH
`define MODE_MAP_CFG_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_PRIORITY_AND_MODE_CONTROL 8'h3C
`define OFS_RAM_REGISTER_MAP_POSITION 8'h3D
`define OFS_SYSTEM_CONFIGURATION_LATCHES 8'h3F

// ---------------------------------------------------------------
// Field positions of priority_and_mode_control
// ---------------------------------------------------------------
`define PMC_BOOT_BIT 7
`define PMC_SPECIAL_BIT 6
`define PMC_MODE_A_BIT 5
`define PMC_PSEL_HI 4
`define PMC_PSEL_RST 5'h06

// ---------------------------------------------------------------
// Field positions of system_configuration_latches
// ---------------------------------------------------------------
`define CFG_ROM_HIGH_BIT 7
`define CFG_FIXED_BIT 6
`define CFG_AUX_CLK_BIT 5
`define CFG_PULLUP_BIT 4
`define CFG_SEC_OFF_BIT 3
`define CFG_WDOG_OFF_BIT 2
`define CFG_ROM_ON_BIT 1
`define CFG_EEPROM_ON_BIT 0
`define CFG_RST 8'hFF
`define CFG_UNUSED_MASK 8'h40

// ---------------------------------------------------------------
// Mapping reset value
// ---------------------------------------------------------------
`define MAP_RST 8'h00

// ---------------------------------------------------------------
// Memory map limits
// ---------------------------------------------------------------
`define BOOT_LO 16'hBE00
`define BOOT_HI 16'hBFFF
`define ROM_LOW_LO 16'h2000
`define ROM_LOW_HI 16'h7FFF
`define ROM_HIGH_LO 16'hA000
`define ROM_HIGH_HI 16'hFFFF
`define RAM_SIZE 12'h300
`define REG_SIZE 12'h080

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define MAP_WINDOW_CYCLES 7'h40
`define SYNC_CYCLES 2'h2
`define AUX_DIV_HALF 4'h2

`endif

// >>> rtl/aux_clock_divider.v
// Purpose: Divides the reference clock down for the auxiliary clock pin
// Assumes: Enable comes from a flip-flop on the same clock
// Notes: Pin is held low while disabled

`include "mode_map_cfg_map.vh"

module aux_clock_divider (
	input wire ref_clk_i,
	input wire resetn_i,
	input wire enable_i,
	output reg aux_clock_o
);

reg [3:0] half_cnt;

// ---------------------------------------------------------------
// Divider
// ---------------------------------------------------------------
always @(posedge ref_clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		half_cnt <= 4'h0;
		aux_clock_o <= 1'b0;
	end else if (!enable_i) begin
		half_cnt <= 4'h0;
		aux_clock_o <= 1'b0;
	end else if (half_cnt == `AUX_DIV_HALF - 4'h1) begin
		half_cnt <= 4'h0;
		aux_clock_o <= ~aux_clock_o;
	end else begin
		half_cnt <= half_cnt + 4'h1;
	end
end

endmodule // aux_clock_divider

// >>> test/mode_and_memory_map_config_asserts.sv
// Purpose: Port checks of the mode and memory map configuration block
// Assumes: Mode pins stay stable across every reset sequence
// Notes: Bound to the block below
module mode_map_cfg_asserts (
	input wire ref_clk_i,
	input wire resetn_i,
	input wire [7:0] addr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire mode_pin_a_i,
	input wire mode_pin_b_i,
	input wire [15:0] cpu_addr_i,
	input wire ram_select_o,
	input wire reg_select_o,
	input wire rom_select_o,
	input wire boot_rom_select_o,
	input wire special_mode_flag_o,
	input wire mode_select_a_o,
	input wire boot_rom_visible_o,
	input wire [3:0] ram_base_o,
	input wire [3:0] reg_base_o,
	input wire rom_high_placement_o,
	input wire rom_present_o,
	input wire config_ready_o
);
	// ---------------------------------------------------------------
	// Cycles since the reset sequence finished
	// ---------------------------------------------------------------
	logic [6:0] cycles_after_ready;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			cycles_after_ready <= 7'h00;
		else if (config_ready_o && cycles_after_ready != 7'h7F)
			cycles_after_ready <= cycles_after_ready + 7'h01;
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	mode_latch_a: assert property ($rose(config_ready_o) |->
		special_mode_flag_o == !mode_pin_b_i && mode_select_a_o == mode_pin_a_i) else $error("Mode bits differ from pins");
	special_no_set_a: assert property (config_ready_o && !special_mode_flag_o |=> !special_mode_flag_o)
		else $error("Special mode flag set again");
	boot_needs_special_a: assert property (config_ready_o && !special_mode_flag_o |=> !boot_rom_visible_o)
		else $error("Boot ROM visible without special mode");
	boot_window_a: assert property (boot_rom_select_o |-> ($past(cpu_addr_i) & 16'hFE00) == 16'hBE00)
		else $error("Boot ROM selected outside its range");
	map_locked_a: assert property (cycles_after_ready > 7'h3B && !special_mode_flag_o |=>
		$stable(ram_base_o) && $stable(reg_base_o)) else $error("Mapping changed after its window");
	ram_place_a: assert property (ram_select_o |-> ($past(cpu_addr_i) & 16'hF000) == {ram_base_o, 12'h000}
		&& ($past(cpu_addr_i) & 16'h0FFF) < 16'h0300) else $error("RAM selected off its base");
	reg_place_a: assert property (reg_select_o |->
		($past(cpu_addr_i) & 16'hFF80) == {reg_base_o, 12'h000}) else $error("Register block selected off its base");
	cfg_bit_six_a: assert property (rd_i && addr_i == 8'h3F |=> rdata_o[6])
		else $error("Configuration bit 6 read as zero");
	single_rom_a: assert property ($rose(config_ready_o) && mode_pin_b_i && !mode_pin_a_i |->
		rom_high_placement_o && rom_present_o) else $error("Single chip ROM not forced high");
	rom_range_a: assert property (rom_select_o |-> $past(cpu_addr_i) >= 16'hA000
		|| ($past(cpu_addr_i) >= 16'h2000 && $past(cpu_addr_i) <= 16'h7FFF)) else $error("ROM selected off range");
	test_rom_off_a: assert property ($rose(config_ready_o) && !mode_pin_b_i && mode_pin_a_i |-> !rom_present_o)
		else $error("Special test ROM not removed");
endmodule // mode_map_cfg_asserts

bind mode_and_memory_map_config mode_map_cfg_asserts mode_map_cfg_asserts_inst (.*);

// >>> test/mode_and_memory_map_config_test.sv
// Purpose: Self-checking bench of the mode and memory map configuration block
// Assumes: Register bus with read data one cycle after the strobe
// Notes: Each scenario is one task
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h, expected %h", $time, g, e); end end

module mode_and_memory_map_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i, resetn_i, wr_i, rd_i, mode_pin_a_i, mode_pin_b_i, config_ready_o, aux_clock_pin_o;
	logic [7:0] addr_i, wdata_i, nv_config_i, rdata_o;
	logic [15:0] cpu_addr_i;
	logic ram_select_o, reg_select_o, rom_select_o, boot_rom_select_o, special_mode_flag_o, mode_select_a_o;
	logic boot_rom_visible_o, rom_high_placement_o, rom_present_o, watchdog_disable_o, security_disable_o;
	logic eeprom_present_o, pullup_assign_enable_o;
	logic [3:0] ram_base_o, reg_base_o;
	int n_errors, num_checks;

	mode_and_memory_map_config mode_and_memory_map_config_inst (.*);

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// ---------------------------------------------------------------
	// Bus and port tasks
	// ---------------------------------------------------------------
	task automatic start(input logic b, input logic a, input logic [7:0] nv);
		int i;
		@(posedge ref_clk_i);
		mode_pin_b_i <= b;
		mode_pin_a_i <= a;
		nv_config_i <= nv;
		resetn_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		for (i = 0; i < 20 && config_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
		`CHK(config_ready_o, 1'b1)
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		`CHK(rdata_o, e)
	endtask

	task automatic dec(input logic [15:0] a, input logic [3:0] e);
		@(posedge ref_clk_i);
		cpu_addr_i <= a;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		`CHK({reg_select_o, ram_select_o, rom_select_o, boot_rom_select_o}, e)
	endtask

	task automatic aux(input int e);
		int i, n;
		logic p;
		n = 0;
		@(negedge ref_clk_i);
		p = aux_clock_pin_o;
		for (i = 0; i < 8; i++) begin
			@(negedge ref_clk_i);
			if (aux_clock_pin_o !== p) n++;
			p = aux_clock_pin_o;
		end
		`CHK(n, e)
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_modes();
		logic [1:0] pins [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
		logic [7:0] hp [4] = '{8'h06, 8'h26, 8'hC6, 8'h66};
		logic [7:0] cf [4] = '{8'hE3, 8'h63, 8'h63, 8'h61};
		int i;
		for (i = 0; i < 4; i++) begin
			start(pins[i][1], pins[i][0], 8'h23);
			rdc(8'h3C, hp[i]);
			`CHK({boot_rom_visible_o, special_mode_flag_o, mode_select_a_o}, hp[i][7:5])
			rdc(8'h3F, cf[i]);
			`CHK({rom_high_placement_o, rom_present_o}, {cf[i][7], cf[i][1]})
			`CHK({pullup_assign_enable_o, security_disable_o}, cf[i][4:3])
			`CHK({watchdog_disable_o, eeprom_present_o}, {cf[i][2], cf[i][0]})
			rdc(8'h3D, 8'h00);
			`CHK({ram_base_o, reg_base_o}, 8'h00)
			dec(16'h0010, 4'b1000);
		end
	endtask

	task automatic t_normal();
		start(1'b1, 1'b1, 8'h23);
		aux(4);
		wr(8'h3C, 8'h00);
		wr(8'h3C, 8'hE0);
		rdc(8'h3C, 8'h00);
		`CHK({special_mode_flag_o, mode_select_a_o}, 2'b00)
		wr(8'h3D, 8'h12);
		wr(8'h3D, 8'h34);
		rdc(8'h3D, 8'h12);
		`CHK({ram_base_o, reg_base_o}, 8'h12)
		dec(16'h1100, 4'b0100);
		dec(16'h2040, 4'b1000);
		dec(16'h7FFF, 4'b0010);
		dec(16'hA000, 4'b0000);
		dec(16'hBE10, 4'b0000);
		wr(8'h3F, 8'h00);
		nv_config_i <= 8'h00;
		rdc(8'h3F, 8'h63);
		start(1'b1, 1'b1, 8'h00);
		rdc(8'h3F, 8'h40);
		aux(0);
		`CHK(aux_clock_pin_o, 1'b0)
		dec(16'h7FFF, 4'b0000);
		repeat (70) @(posedge ref_clk_i);
		wr(8'h3D, 8'h55);
		rdc(8'h3D, 8'h00);
	endtask

	task automatic t_special();
		start(1'b0, 1'b1, 8'h00);
		wr(8'h3C, 8'hC0);
		rdc(8'h3C, 8'hC0);
		wr(8'h3C, 8'hE0);
		rdc(8'h3C, 8'hE0);
		dec(16'hBE10, 4'b0001);
		dec(16'hBFFF, 4'b0001);
		dec(16'hC000, 4'b0000);
		wr(8'h3F, 8'h82);
		rdc(8'h3F, 8'hC2);
		`CHK({rom_high_placement_o, rom_present_o}, 2'b11)
		dec(16'hA000, 4'b0010);
		dec(16'h9FFF, 4'b0000);
		wr(8'h3F, 8'h20);
		wr(8'h3D, 8'h11);
		aux(4);
		repeat (70) @(posedge ref_clk_i);
		wr(8'h3D, 8'h22);
		rdc(8'h3D, 8'h22);
		`CHK({ram_base_o, reg_base_o}, 8'h22)
		wr(8'h3C, 8'h80);
		dec(16'hBE10, 4'b0000);
		`CHK({special_mode_flag_o, boot_rom_visible_o}, 2'b00)
		rdc(8'h3C, 8'h80);
		wr(8'h3F, 8'h00);
		rdc(8'h3F, 8'h60);
	endtask

	// ---------------------------------------------------------------
	// Sequence and verdict
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		n_errors = 0;
		num_checks = 0;
		resetn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		mode_pin_a_i = 1'b0;
		mode_pin_b_i = 1'b1;
		nv_config_i = 8'h00;
		cpu_addr_i = 16'h0000;
		t_modes();
		t_normal();
		t_special();
		stop_test();
	end

	initial begin
		#(3000 * 25);
		n_errors++;
		stop_test();
	end
endmodule // mode_and_memory_map_config_test
